// File: hdl/fec_counters.sv
// framing error counters with apb register access
//
// Contract
// - T1 multiframe mode: count each multiframe boundary seen while sync is lost.
// - T1 bit-error mode: count terminal framing errors in D4, sequence errors in ESF.
// - T1 bit-error mode: no counting while receive sync is lost.
// - E1: count frame alignment word errors; none while sync lost.
// - E1: ignore alignment word errors during any alignment or multiframe search.
// - sync-loss count is 16 bits: high byte at 46h, low at 47h.
// - far-end error counter counts only in E1 mode.
// - with CRC4 multiframing, count each received E-bit equal to zero.
// - far-end counting stops on alignment or CRC4 loss, not CAS loss.
// - far-end count is 16 bits: high byte at 48h, low at 49h.
// - counters never overflow; they hold at full scale.
// - count-select bit: 0 framing-bit errors, 1 multiframes out of sync.
// - each interval (1 s, 42 ms or 62.5 ms) latches then clears counters.
// - manual mode: rising manual-update bit latches and clears; host waits.
//
// Decided for this implementation: the APB register port.
`default_nettype none
module fec_counters
  import fec_pkg::*;
#(
  parameter int unsigned LONG_PERIOD     = LONG_CYCLES,
  parameter int unsigned T1_SHORT_PERIOD = T1_SHORT_CYCLES,
  parameter int unsigned E1_SHORT_PERIOD = E1_SHORT_CYCLES
) (
  input  wire logic        CLK_SYS,
  input  wire logic        ARST_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        RX_SYNC_LOST,
  input  wire logic        RX_MF_BOUNDARY,
  input  wire logic        RX_FT_ERR,
  input  wire logic        RX_FPS_ERR,
  input  wire logic        RX_FAS_ERR,
  input  wire logic        RX_FAS_SEARCH,
  input  wire logic        RX_CAS_SEARCH,
  input  wire logic        RX_CRC4_SEARCH,
  input  wire logic        RX_CRC4_SYNC_LOST,
  input  wire logic        RX_EBIT_VALID,
  input  wire logic        RX_EBIT
);

  // true when an access hits the given register index
  function automatic logic hit(input logic [11:0] addr, input logic [9:0] idx);
    hit = (addr[1:0] == 2'h0) && (addr[11:2] == idx);
  endfunction

  // true when the address maps to any register
  function automatic logic mapped(input logic [11:0] addr);
    mapped = hit(addr, IDX_ERR_CFG) || hit(addr, IDX_SYNC_HIGH) || hit(addr, IDX_SYNC_LOW) ||
             hit(addr, IDX_FAR_HIGH) || hit(addr, IDX_FAR_LOW) || hit(addr, IDX_LINE_CFG) ||
             hit(addr, IDX_STATUS);
  endfunction

  logic [7:0]         err_cfg;
  logic [7:0]         line_cfg;
  logic               manual_prev;
  logic               latch_now;
  logic [TIMER_W-1:0] timer;
  logic [TIMER_W-1:0] period;
  logic               timer_done;
  logic               manual_edge;
  logic               wr_access;
  logic               setup_phase;
  logic [CNT_N-1:0]   inc;
  logic [CNT_W-1:0]   run  [CNT_N];
  logic [CNT_W-1:0]   snap [CNT_N];
  logic [7:0]         next_rdata;

  // configuration fields
  logic count_select;
  logic accum_manual;
  logic short_interval;
  logic manual_update;
  logic e1_mode;
  logic esf_mode;
  logic crc4_enable;

  assign count_select   = err_cfg[CFG_COUNT_SELECT_POS];
  assign accum_manual   = err_cfg[CFG_ACCUM_MODE_POS];
  assign short_interval = err_cfg[CFG_INTERVAL_SELECT_POS];
  assign manual_update  = err_cfg[CFG_MANUAL_UPDATE_POS];
  assign e1_mode        = line_cfg[LINE_E1_POS];
  assign esf_mode       = line_cfg[LINE_ESF_POS];
  assign crc4_enable    = line_cfg[LINE_CRC4_POS];

  // apb phase decode
  assign setup_phase = PSEL && !PENABLE;
  assign wr_access   = PSEL && PENABLE && PREADY && PWRITE;

  // read setup strobe, used for data capture
  logic rd_setup;
  assign rd_setup = setup_phase && !PWRITE;

  // per-register write enables
  logic cfg_wr;
  logic line_wr;
  assign cfg_wr  = wr_access && hit(PADDR, IDX_ERR_CFG);
  assign line_wr = wr_access && hit(PADDR, IDX_LINE_CFG);

  // status byte: running counts nonzero and receive loss levels
  logic [7:0] status_byte;
  assign status_byte = {4'h0, RX_CRC4_SYNC_LOST, RX_SYNC_LOST, (run[1] != CNT_RESET), (run[0] != CNT_RESET)};

  // apb ready: one wait-free access phase after each setup
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      PREADY <= 1'b0;
    end else begin
      PREADY <= setup_phase;
    end
  end

  // error flag for unmapped addresses, raised with ready
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      PSLVERR <= 1'b0;
    end else begin
      PSLVERR <= setup_phase && !mapped(PADDR);
    end
  end

  // read data selection; counts come from the snapshot only
  always_comb begin
    next_rdata = 8'h00;
    if (hit(PADDR, IDX_ERR_CFG)) begin
      next_rdata = err_cfg;
    end else if (hit(PADDR, IDX_SYNC_HIGH)) begin
      next_rdata = snap[0][15:8];
    end else if (hit(PADDR, IDX_SYNC_LOW)) begin
      next_rdata = snap[0][7:0];
    end else if (hit(PADDR, IDX_FAR_HIGH)) begin
      next_rdata = snap[1][15:8];
    end else if (hit(PADDR, IDX_FAR_LOW)) begin
      next_rdata = snap[1][7:0];
    end else if (hit(PADDR, IDX_LINE_CFG)) begin
      next_rdata = line_cfg;
    end else if (hit(PADDR, IDX_STATUS)) begin
      next_rdata = status_byte;
    end
  end

  // read data captured in the setup cycle, upper bits read zero
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      PRDATA <= 32'h0000_0000;
    end else if (rd_setup) begin
      PRDATA <= {24'h00_0000, next_rdata};
    end else if (setup_phase && !mapped(PADDR)) begin
      PRDATA <= 32'h0000_0000;                      // refused write shows no stale data
    end
  end

  // error counter configuration register
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      err_cfg <= ERR_CFG_RESET;
    end else if (cfg_wr) begin
      err_cfg <= PWDATA[7:0] & ERR_CFG_MASK;
    end
  end

  // line configuration register
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      line_cfg <= LINE_CFG_RESET;
    end else if (line_wr) begin
      line_cfg <= PWDATA[7:0] & LINE_CFG_MASK;
    end
  end

  // accumulation period selection
  always_comb begin
    if (!short_interval) begin
      period = TIMER_W'(LONG_PERIOD);
    end else if (e1_mode) begin
      period = TIMER_W'(E1_SHORT_PERIOD);
    end else begin
      period = TIMER_W'(T1_SHORT_PERIOD);
    end
  end

  assign timer_done  = !accum_manual && (timer >= period - TIMER_W'(1));
  assign manual_edge = accum_manual && manual_update && !manual_prev;

  // interval timer, held at zero in manual mode
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      timer <= '0;
    end else if (accum_manual || timer_done) begin
      timer <= '0;
    end else begin
      timer <= timer + TIMER_W'(1);
    end
  end

  // previous manual-update bit for edge detection
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      manual_prev <= 1'b0;
    end else begin
      manual_prev <= manual_update;
    end
  end

  // latch strobe one cycle after interval end or manual edge
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      latch_now <= 1'b0;
    end else begin
      latch_now <= timer_done || manual_edge;
    end
  end

  // qualified receive events, one wire per counting source
  logic t1_frame_bit_err;
  logic t1_mf_out_of_sync;
  logic e1_align_hunting;
  logic e1_align_word_err;
  logic far_end_blocked;
  logic e1_far_end_err;

  // t1 framing-bit error source follows the framing mode
  assign t1_frame_bit_err = esf_mode ? RX_FPS_ERR : RX_FT_ERR;

  // t1 multiframe boundary seen while sync is lost
  assign t1_mf_out_of_sync = RX_MF_BOUNDARY && RX_SYNC_LOST;

  // any alignment or multiframe search in progress
  assign e1_align_hunting = RX_FAS_SEARCH || RX_CAS_SEARCH || RX_CRC4_SEARCH;

  // e1 alignment word error outside loss and search
  assign e1_align_word_err = RX_FAS_ERR && !RX_SYNC_LOST && !e1_align_hunting;

  // far-end counting blocked by alignment or crc4 loss; cas loss ignored
  assign far_end_blocked = RX_SYNC_LOST || RX_CRC4_SYNC_LOST;

  // received e-bit at zero with crc4 multiframing
  assign e1_far_end_err = crc4_enable && RX_EBIT_VALID && !RX_EBIT && !far_end_blocked;

  // sync-loss counter increment by mode
  always_comb begin
    if (e1_mode) begin
      inc[0] = e1_align_word_err;
    end else if (count_select) begin
      inc[0] = t1_mf_out_of_sync;
    end else begin
      inc[0] = t1_frame_bit_err && !RX_SYNC_LOST;
    end
  end

  // far-end error counter increment, e1 only
  always_comb begin
    inc[1] = e1_mode && e1_far_end_err;
  end

  // next running value, held at full scale
  function automatic logic [CNT_W-1:0] sat_next(input logic [CNT_W-1:0] cur, input logic step);
    if (step && (cur != CNT_MAX)) begin
      sat_next = cur + 16'h0001;
    end else begin
      sat_next = cur;
    end
  endfunction

  // running counters and snapshots; an event on the latch cycle starts the new period
  genvar g;
  generate
    for (g = 0; g < CNT_N; g++) begin : g_cnt
      always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
          run[g] <= CNT_RESET;
        end else if (latch_now) begin
          run[g] <= {15'h0000, inc[g]};
        end else begin
          run[g] <= sat_next(run[g], inc[g]);
        end
      end

      always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
          snap[g] <= CNT_RESET;
        end else if (latch_now) begin
          snap[g] <= run[g];
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// File: hdl/fec_pkg.sv
// constants for the framing error counter block
`default_nettype none
package fec_pkg;
  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_ERR_CFG       = 10'h041;
  localparam logic [9:0] IDX_SYNC_HIGH     = 10'h046;
  localparam logic [9:0] IDX_SYNC_LOW      = 10'h047;
  localparam logic [9:0] IDX_FAR_HIGH      = 10'h048;
  localparam logic [9:0] IDX_FAR_LOW       = 10'h049;
  localparam logic [9:0] IDX_LINE_CFG      = 10'h050;
  localparam logic [9:0] IDX_STATUS        = 10'h051;

  // error_counter_config field positions
  localparam int CFG_COUNT_SELECT_POS      = 1;
  localparam int CFG_ACCUM_MODE_POS        = 4;
  localparam int CFG_INTERVAL_SELECT_POS   = 5;
  localparam int CFG_MANUAL_UPDATE_POS     = 6;
  localparam logic [7:0] ERR_CFG_MASK      = 8'h72;
  localparam logic [7:0] ERR_CFG_RESET     = 8'h00;

  // line configuration field positions
  localparam int LINE_E1_POS               = 0;
  localparam int LINE_ESF_POS              = 1;
  localparam int LINE_CRC4_POS             = 2;
  localparam logic [7:0] LINE_CFG_MASK     = 8'h07;
  localparam logic [7:0] LINE_CFG_RESET    = 8'h00;

  // counters
  localparam int          CNT_W            = 16;
  localparam int          CNT_N            = 2;
  localparam logic [15:0] CNT_MAX          = 16'hFFFF;
  localparam logic [15:0] CNT_RESET        = 16'h0000;

  // accumulation timing
  localparam int CLK_PERIOD_NS             = 50;
  localparam int LONG_TIME_US              = 1000000;
  localparam int T1_SHORT_TIME_US          = 42000;
  localparam int E1_SHORT_TIME_US          = 62500;
  localparam int LONG_CYCLES               = LONG_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int T1_SHORT_CYCLES           = T1_SHORT_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int E1_SHORT_CYCLES           = E1_SHORT_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int TIMER_W                   = 25;
endpackage
`default_nettype wire

// File: test/fec_counters_chk.sv
// port checker for the framing error counters
`default_nettype none
module fec_counters_chk
  import fec_pkg::*;
(
  input wire logic        CLK_SYS,
  input wire logic        ARST_N,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);
  // apb setup cycle
  sequence setup_s;
    PSEL && !PENABLE;
  endsequence
  ready_after_setup_a: assert property (setup_s |=> PREADY) else $error("no ready after setup");
  ready_cause_a: assert property (PREADY |-> $past(PSEL && !PENABLE)) else $error("stray ready");
  ready_single_a: assert property (PREADY |=> !PREADY) else $error("ready too long");
  err_with_ready_a: assert property (PSLVERR |-> PREADY) else $error("error without ready");
  misalign_err_a: assert property (setup_s ##0 PADDR[1:0] != 2'b00 |=> PSLVERR) else $error("misaligned accepted");
  upper_zero_a: assert property (PREADY |-> PRDATA[31:8] == 24'h0) else $error("upper data set");
  count_ok_a: assert property (setup_s ##0 (PADDR[1:0] == 2'b00 && PADDR[11:2] >= IDX_SYNC_HIGH
    && PADDR[11:2] <= IDX_FAR_LOW) |=> !PSLVERR) else $error("count register refused");
  err_data_a: assert property (PSLVERR |-> PRDATA == 32'h0) else $error("data on error");
endmodule
bind fec_counters fec_counters_chk u_chk (.CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .PSEL(PSEL),
  .PENABLE(PENABLE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR));
`default_nettype wire

// File: test/fec_framer_model.sv
// receive framer model: sync levels and event pulses
`default_nettype none
module fec_framer_model (
  input  wire logic clk,
  output wire logic sync_lost,
  output wire logic fas_search,
  output wire logic cas_search,
  output wire logic crc4_search,
  output wire logic crc4_lost,
  output wire logic mf_boundary,
  output wire logic frame_bit_err,
  output wire logic seq_err,
  output wire logic fas_err,
  output wire logic ebit_valid,
  output wire logic ebit
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [10:0] rx;
  initial rx = 11'h000;
  // each line to its own pin
  assign sync_lost     = rx[0];
  assign fas_search    = rx[1];
  assign cas_search    = rx[2];
  assign crc4_search   = rx[3];
  assign crc4_lost     = rx[4];
  assign mf_boundary   = rx[5];
  assign frame_bit_err = rx[6];
  assign seq_err       = rx[7];
  assign fas_err       = rx[8];
  assign ebit_valid    = rx[9];
  assign ebit          = rx[10];
  // levels: 0 lost, 1 fas search, 2 cas search, 3 crc4 search, 4 crc4 lost
  task automatic lvl(input logic [4:0] v);
    @(posedge clk);
    rx[4:0] <= v;
  endtask
  // one-cycle pulse; e-bit line shows the inverse once released
  task automatic pulse(input int b, input logic e);
    @(posedge clk);
    rx[b] <= 1'b1;
    rx[10] <= e;
    @(posedge clk);
    rx[b] <= 1'b0;
    rx[10] <= ~e;
  endtask
endmodule
`default_nettype wire

// File: test/tb_fec_counters.sv
// testbench for the framing error counters
`default_nettype none
module tb_fec_counters
  import fec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, pready, pslverr, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  wire         sl, fs, cs, c4s, c4l, mfb, fbe, sqe, fae, ebv, eb;
  int          failures = 0, cmp_count = 0;
  initial forever #25 clk = ~clk;
  fec_framer_model u_fr (.clk(clk), .sync_lost(sl), .fas_search(fs), .cas_search(cs), .crc4_search(c4s),
    .crc4_lost(c4l), .mf_boundary(mfb), .frame_bit_err(fbe), .seq_err(sqe), .fas_err(fae),
    .ebit_valid(ebv), .ebit(eb));
  fec_counters #(.LONG_PERIOD(100), .T1_SHORT_PERIOD(20), .E1_SHORT_PERIOD(25)) u_dut (
    .CLK_SYS(clk), .ARST_N(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .RX_SYNC_LOST(sl), .RX_FAS_SEARCH(fs), .RX_CAS_SEARCH(cs), .RX_CRC4_SEARCH(c4s),
    .RX_CRC4_SYNC_LOST(c4l), .RX_MF_BOUNDARY(mfb), .RX_FT_ERR(fbe), .RX_FPS_ERR(sqe),
    .RX_FAS_ERR(fae), .RX_EBIT_VALID(ebv), .RX_EBIT(eb));
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer, waits for ready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (n >= 20) chk(32'h1, 32'h0);
  endtask
  // manual latch, then read both counts
  task automatic snap(input logic [7:0] c, input logic [15:0] s, input logic [15:0] f);
    apb(1'b1, {IDX_ERR_CFG, 2'b00}, {24'h0, c | 8'h10});
    apb(1'b1, {IDX_ERR_CFG, 2'b00}, {24'h0, c | 8'h50});
    repeat (2) @(posedge clk);
    apb(1'b0, {IDX_SYNC_HIGH, 2'b00}, 32'h0);
    chk(rd, {24'h0, s[15:8]});
    apb(1'b0, {IDX_SYNC_LOW, 2'b00}, 32'h0);
    chk(rd, {24'h0, s[7:0]});
    apb(1'b0, {IDX_FAR_HIGH, 2'b00}, 32'h0);
    chk(rd, {24'h0, f[15:8]});
    apb(1'b0, {IDX_FAR_LOW, 2'b00}, 32'h0);
    chk(rd, {24'h0, f[7:0]});
  endtask
  // verdict
  task automatic results();
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // hang guard
  initial begin
    #1500000;
    failures++;
    results();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, {IDX_SYNC_HIGH + 10'(i), 2'b00}, 32'h0);
      chk(rd, 32'h0);
    end
    apb(1'b1, {IDX_SYNC_LOW, 2'b00}, 32'hFF);
    apb(1'b0, {IDX_SYNC_LOW, 2'b00}, 32'h0);
    chk({er, rd[30:0]}, 32'h0);
    apb(1'b0, {IDX_SYNC_LOW, 2'b01}, 32'h0);
    chk({31'h0, er}, 32'h1);
    // t1 d4, framing-bit mode
    apb(1'b1, {IDX_ERR_CFG, 2'b00}, 32'h10);
    repeat (3) u_fr.pulse(6, 1'b0);
    u_fr.pulse(7, 1'b0);
    u_fr.pulse(9, 1'b0);
    u_fr.lvl(5'h01);
    repeat (2) u_fr.pulse(6, 1'b0);
    u_fr.pulse(5, 1'b0);
    u_fr.lvl(5'h00);
    snap(8'h00, 16'd3, 16'd0);
    // t1 esf, then multiframe mode
    apb(1'b1, {IDX_LINE_CFG, 2'b00}, 32'h02);
    repeat (2) u_fr.pulse(7, 1'b0);
    u_fr.pulse(6, 1'b0);
    snap(8'h00, 16'd2, 16'd0);
    apb(1'b1, {IDX_ERR_CFG, 2'b00}, 32'h12);
    u_fr.lvl(5'h01);
    repeat (4) u_fr.pulse(5, 1'b0);
    u_fr.lvl(5'h00);
    u_fr.pulse(5, 1'b0);
    snap(8'h02, 16'd4, 16'd0);
    // e1 with crc4 multiframing
    apb(1'b1, {IDX_LINE_CFG, 2'b00}, 32'h05);
    repeat (4002) u_fr.pulse(8, 1'b0);
    for (int k = 1; k < 4; k++) begin
      u_fr.lvl(5'(1 << k));
      u_fr.pulse(8, 1'b0);
    end
    u_fr.lvl(5'h04);
    u_fr.pulse(9, 1'b0);
    u_fr.lvl(5'h10);
    u_fr.pulse(8, 1'b0);
    u_fr.pulse(9, 1'b0);
    u_fr.lvl(5'h01);
    u_fr.pulse(8, 1'b0);
    u_fr.pulse(9, 1'b0);
    u_fr.lvl(5'h00);
    repeat (2) u_fr.pulse(9, 1'b0);
    u_fr.pulse(9, 1'b1);
    snap(8'h00, 16'd4003, 16'd3);
    results();
  end
endmodule
`default_nettype wire
